// *** gpio3_pkg.sv ***
package gpio3_pkg;

  // ==========================================================
  // Bus geometry
  localparam int AVS_ADDR_W = 8;
  localparam int AVS_DATA_W = 32;
  localparam int AVS_BE_W   = 4;
  localparam int IDX_W      = 6;
  localparam int IDX_LSB    = 2;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_PORT_A_DATA  = 6'h00;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DATA  = 6'h01;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DATA  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_PORT_A_DIR   = 6'h04;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DIR   = 6'h05;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DIR   = 6'h06;
  localparam logic [IDX_W-1:0] IDX_KEY_IRQ_EN   = 6'h17;
  localparam logic [IDX_W-1:0] IDX_PORT_OPTION  = 6'h1A;
  localparam logic [IDX_W-1:0] IDX_PULLUP_CTRL  = 6'h3E;

  // ==========================================================
  // Widths and reset values
  localparam int PORT_W = 8;
  localparam int PC_W   = 4;
  localparam int REG_W  = 8;
  localparam logic [PORT_W-1:0] DIR_RST   = 8'h00;
  localparam logic [PC_W-1:0]   DIR_C_RST = 4'h0;
  localparam logic [REG_W-1:0]  CTRL_RST  = 8'h00;
  localparam logic [AVS_DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // ==========================================================
  // Timer hand-over encodings
  localparam logic [1:0] MODE_PORT   = 2'h0;
  localparam logic [1:0] ELS_PORT    = 2'h0;
  localparam logic [2:0] PS_EXT_CLK  = 3'h7;
  localparam int         PIN_CH0     = 0;
  localparam int         PIN_EXTCLK  = 1;
  localparam int         PIN_CH1     = 2;
  localparam int         PIN_SPARE   = 3;

  // ==========================================================
  // Types
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } gpio3_bus_e;

  typedef struct packed {
    logic [PC_W-1:0][1:0] mode_pair;
    logic [1:0]           els_ch0;
    logic [1:0]           els_ch1;
    logic [2:0]           prescaler;
    logic [PC_W-1:0]      drive;
    logic [PC_W-1:0]      drive_en;
  } gpio3_timer_ctrl_s;

  typedef struct packed {
    logic [PORT_W-1:0] a;
    logic [PORT_W-1:0] b;
    logic [PC_W-1:0]   c;
  } gpio3_pins_s;

endpackage

// *** gpio3_sync.sv ***
`timescale 1ns/10ps
module gpio3_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // ==========================================================
  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // gpio3_sync

// *** gpio3_port.sv ***
`timescale 1ns/10ps
module gpio3_port #(
  parameter int W = 8
) (
  input  wire logic         open_drain,
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] pin_level,
  input  wire logic [W-1:0] timer_own,
  input  wire logic [W-1:0] timer_drive,
  input  wire logic [W-1:0] timer_drive_en,
  output logic      [W-1:0] read_val,
  output logic      [W-1:0] out_next,
  output logic      [W-1:0] oe_next
);

  // ==========================================================
  // Per-pin read mux and drive selection
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      read_val[i] = dir[i] ? latch[i] : pin_level[i];
      if (timer_own[i]) begin
        out_next[i] = timer_drive[i];
        oe_next[i]  = timer_drive_en[i];
      end else if (open_drain) begin
        // Pull low only; a one releases the pin to the pullup
        out_next[i] = 1'b0;
        oe_next[i]  = dir[i] & ~latch[i];
      end else begin
        out_next[i] = latch[i];
        oe_next[i]  = dir[i];
      end
    end
  end

endmodule // gpio3_port

// *** gpio3_top.sv ***
// Operation
// - Direction one enables the pin output buffer; zero leaves it an input.
// - Reset clears all direction bits of ports A, B and C.
// - Reset leaves the port data latches untouched.
// - Direction one: data read returns the stored latch bit.
// - Direction zero: data read returns the sampled pin level.
// - Data writes with byte lane 0 enabled always load the latch; input pins still read the pin.
// - Port B is eight bits, driving outputs open-drain, low only.
// - Each port B pin has its own LED drive select bit.
// - Each port B pin has its own pullup enable bit.
// - Keyboard enable bit makes port A pin an interrupt input with pullup; here the port A direction bit still sets the output enable.
// - Port C has four pins, each claimable by the timer.
// - Timer mode pair nonzero is needed to give the pin to the timer; zero keeps port.
// - Port C pins 0 and 2 follow the channel edge/level select bits.
// - Port C pin 1 feeds the timer clock when the prescaler selects it.
// - Timer-owned pins ignore direction for drive, not for read source.
// - Port C direction has only four bits.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
module gpio3_top
  import gpio3_pkg::*;
(
  input  wire logic                             clk_sys,
  input  wire logic                             reset,
  input  wire logic [gpio3_pkg::AVS_ADDR_W-1:0] avs_address,
  input  wire logic                             avs_read,
  input  wire logic                             avs_write,
  input  wire logic [gpio3_pkg::AVS_DATA_W-1:0] avs_writedata,
  input  wire logic [gpio3_pkg::AVS_BE_W-1:0]   avs_byteenable,
  output logic      [gpio3_pkg::AVS_DATA_W-1:0] avs_readdata,
  output logic                                  avs_waitrequest,
  input  wire gpio3_pkg::gpio3_pins_s           pin_in,
  output gpio3_pkg::gpio3_pins_s                pin_out,
  output gpio3_pkg::gpio3_pins_s                pin_oe,
  output logic      [gpio3_pkg::PORT_W-1:0]     led_drive_select,
  output logic      [gpio3_pkg::PORT_W-1:0]     pullup_b_en,
  output logic      [gpio3_pkg::PORT_W-1:0]     pullup_a_en,
  output logic      [gpio3_pkg::PORT_W-1:0]     keyboard_irq_pins,
  output logic      [gpio3_pkg::PORT_W-1:0]     keyboard_irq_enable,
  input  wire gpio3_pkg::gpio3_timer_ctrl_s     timer_ctrl,
  output logic      [gpio3_pkg::PC_W-1:0]       timer_pin_level,
  output logic                                  timer_ext_clock_pin
);

  import gpio3_pkg::*;

  // ==========================================================
  // Declarations
  gpio3_bus_e bus_state_reg;
  gpio3_bus_e bus_state_next;

  logic [IDX_W-1:0]  req_idx;
  logic              req_pending;
  logic              acc_write;
  logic              wr_lane0;
  logic [REG_W-1:0]  wdata;

  logic [PORT_W-1:0] port_a_data_latch;
  logic [PORT_W-1:0] port_b_data_latch;
  logic [PC_W-1:0]   port_c_data_latch;
  logic [PORT_W-1:0] port_a_direction;
  logic [PORT_W-1:0] port_b_direction;
  logic [PC_W-1:0]   port_c_direction;
  logic [PORT_W-1:0] keyboard_irq_enable_reg;
  logic [PORT_W-1:0] port_option_control;
  logic [PORT_W-1:0] pullup_control;

  gpio3_pins_s       pin_level;
  gpio3_pins_s       read_val;
  gpio3_pins_s       out_next;
  gpio3_pins_s       oe_next;

  logic [PC_W-1:0]   timer_own;
  logic              ext_clk_sel;
  logic [REG_W-1:0]  rd_byte;

  // ==========================================================
  // Pin synchronisers
  gpio3_sync #(
    .W ($bits(gpio3_pins_s))
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in (pin_in),
    .sync_out (pin_level)
  );

  // ==========================================================
  // Bus handshake
  // Every access waits exactly one cycle; read data is captured
  // while waitrequest is high so it is stable at the accept edge.
  assign req_pending = (avs_read | avs_write) & (bus_state_reg == BUS_IDLE);
  assign acc_write   = avs_write & (bus_state_reg == BUS_ACK);
  assign req_idx     = avs_address[IDX_LSB +: IDX_W];
  assign wr_lane0    = acc_write & avs_byteenable[0];
  assign wdata       = avs_writedata[REG_W-1:0];

  always_comb begin
    case (bus_state_reg)
      BUS_IDLE: begin
        bus_state_next = req_pending ? BUS_ACK : BUS_IDLE;
      end
      BUS_ACK: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= (bus_state_next != BUS_ACK);
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    rd_byte = '0;
    if (req_idx == IDX_PORT_A_DATA) begin
      rd_byte = read_val.a;
    end else if (req_idx == IDX_PORT_B_DATA) begin
      rd_byte = read_val.b;
    end else if (req_idx == IDX_PORT_C_DATA) begin
      rd_byte = {4'h0, read_val.c};
    end else if (req_idx == IDX_PORT_A_DIR) begin
      rd_byte = port_a_direction;
    end else if (req_idx == IDX_PORT_B_DIR) begin
      rd_byte = port_b_direction;
    end else if (req_idx == IDX_PORT_C_DIR) begin
      rd_byte = {4'h0, port_c_direction};
    end else if (req_idx == IDX_KEY_IRQ_EN) begin
      rd_byte = keyboard_irq_enable_reg;
    end else if (req_idx == IDX_PORT_OPTION) begin
      rd_byte = port_option_control;
    end else if (req_idx == IDX_PULLUP_CTRL) begin
      rd_byte = pullup_control;
    end else begin
      // Unmapped index reads as zero
      rd_byte = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_readdata <= RDATA_ZERO;
    end else if (req_pending & avs_read) begin
      avs_readdata <= {24'h000000, rd_byte};
    end
  end

  // ==========================================================
  // Data latches
  // No reset here: the latches hold their contents through reset
  always_ff @(posedge clk_sys) begin
    if (wr_lane0 && req_idx == IDX_PORT_A_DATA) begin
      port_a_data_latch <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_lane0 && req_idx == IDX_PORT_B_DATA) begin
      port_b_data_latch <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_lane0 && req_idx == IDX_PORT_C_DATA) begin
      port_c_data_latch <= wdata[PC_W-1:0];
    end
  end

  // ==========================================================
  // Direction registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port_a_direction <= DIR_RST;
    end else if (wr_lane0 && req_idx == IDX_PORT_A_DIR) begin
      port_a_direction <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port_b_direction <= DIR_RST;
    end else if (wr_lane0 && req_idx == IDX_PORT_B_DIR) begin
      port_b_direction <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port_c_direction <= DIR_C_RST;
    end else if (wr_lane0 && req_idx == IDX_PORT_C_DIR) begin
      port_c_direction <= wdata[PC_W-1:0];
    end
  end

  // ==========================================================
  // Option registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      keyboard_irq_enable_reg <= CTRL_RST;
    end else if (wr_lane0 && req_idx == IDX_KEY_IRQ_EN) begin
      keyboard_irq_enable_reg <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port_option_control <= CTRL_RST;
    end else if (wr_lane0 && req_idx == IDX_PORT_OPTION) begin
      port_option_control <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pullup_control <= CTRL_RST;
    end else if (wr_lane0 && req_idx == IDX_PULLUP_CTRL) begin
      pullup_control <= wdata;
    end
  end

  // ==========================================================
  // Timer ownership of port C
  // A channel with edge/level select at zero stays general purpose
  // even with a nonzero mode pair.
  assign ext_clk_sel = (timer_ctrl.prescaler == PS_EXT_CLK);

  always_comb begin
    timer_own = '0;
    timer_own[PIN_CH0] = (timer_ctrl.mode_pair[PIN_CH0] != MODE_PORT) &
                         (timer_ctrl.els_ch0 != ELS_PORT);
    timer_own[PIN_EXTCLK] = (timer_ctrl.mode_pair[PIN_EXTCLK] != MODE_PORT) &
                            ext_clk_sel;
    timer_own[PIN_CH1] = (timer_ctrl.mode_pair[PIN_CH1] != MODE_PORT) &
                         (timer_ctrl.els_ch1 != ELS_PORT);
    timer_own[PIN_SPARE] = (timer_ctrl.mode_pair[PIN_SPARE] != MODE_PORT);
  end

  // ==========================================================
  // Port pin logic
  gpio3_port #(
    .W (PORT_W)
  ) u_port_a (
    .open_drain     (1'b0),
    .latch          (port_a_data_latch),
    .dir            (port_a_direction),
    .pin_level      (pin_level.a),
    .timer_own      ('0),
    .timer_drive    ('0),
    .timer_drive_en ('0),
    .read_val       (read_val.a),
    .out_next       (out_next.a),
    .oe_next        (oe_next.a)
  );

  gpio3_port #(
    .W (PORT_W)
  ) u_port_b (
    .open_drain     (1'b1),
    .latch          (port_b_data_latch),
    .dir            (port_b_direction),
    .pin_level      (pin_level.b),
    .timer_own      ('0),
    .timer_drive    ('0),
    .timer_drive_en ('0),
    .read_val       (read_val.b),
    .out_next       (out_next.b),
    .oe_next        (oe_next.b)
  );

  gpio3_port #(
    .W (PC_W)
  ) u_port_c (
    .open_drain     (1'b0),
    .latch          (port_c_data_latch),
    .dir            (port_c_direction),
    .pin_level      (pin_level.c),
    .timer_own      (timer_own),
    .timer_drive    (timer_ctrl.drive),
    .timer_drive_en (timer_ctrl.drive_en),
    .read_val       (read_val.c),
    .out_next       (out_next.c),
    .oe_next        (oe_next.c)
  );

  // ==========================================================
  // Registered pin drive
  // Drive level is reset too, so the pads see no unknown during reset
  // even though the latches themselves are not reset.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= out_next;
      pin_oe  <= oe_next;
    end
  end

  // ==========================================================
  // Pad options
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      led_drive_select <= CTRL_RST;
      pullup_b_en      <= CTRL_RST;
      pullup_a_en      <= CTRL_RST;
    end else begin
      led_drive_select <= port_option_control;
      pullup_b_en      <= pullup_control;
      pullup_a_en      <= keyboard_irq_enable_reg;
    end
  end

  // ==========================================================
  // Keyboard interrupt inputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      keyboard_irq_pins   <= '0;
      keyboard_irq_enable <= '0;
    end else begin
      keyboard_irq_pins   <= pin_level.a & keyboard_irq_enable_reg;
      keyboard_irq_enable <= keyboard_irq_enable_reg;
    end
  end

  // ==========================================================
  // Timer inputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timer_pin_level     <= '0;
      timer_ext_clock_pin <= 1'b0;
    end else begin
      timer_pin_level     <= pin_level.c & timer_own;
      timer_ext_clock_pin <= pin_level.c[PIN_EXTCLK] & ext_clk_sel;
    end
  end

endmodule // gpio3_top

// *** gpio3_pins_model.sv ***
`timescale 1ns/10ps
module gpio3_pins_model
  import gpio3_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire gpio3_pkg::gpio3_pins_s       pin_out,
  input  wire gpio3_pkg::gpio3_pins_s       pin_oe,
  input  wire gpio3_pkg::gpio3_pins_s       ext,
  input  wire gpio3_pkg::gpio3_pins_s       ext_en,
  input  wire logic [gpio3_pkg::PORT_W-1:0] pullup_a_en,
  input  wire logic [gpio3_pkg::PORT_W-1:0] pullup_b_en,
  output gpio3_pkg::gpio3_pins_s            pin_in
);
  // ==========================================================
  // Pad level resolution
  // Undriven, unpulled pads wander so a stale value never passes
  logic       tgl = 1'b0;
  logic [7:0] lvl_c;

  function automatic logic [7:0] lvl(input logic [7:0] oe, o, en, x, pu, input logic t);
    return (oe & o) | (~oe & en & x) | (~oe & ~en & (pu | {8{t}}));
  endfunction

  always_ff @(posedge clk_sys) begin
    tgl <= ~tgl;
  end

  always_comb begin
    pin_in.a = lvl(pin_oe.a, pin_out.a, ext_en.a, ext.a, pullup_a_en, tgl);
    pin_in.b = lvl(pin_oe.b, pin_out.b, ext_en.b, ext.b, pullup_b_en, tgl);
    lvl_c = lvl({4'h0, pin_oe.c}, {4'h0, pin_out.c}, {4'h0, ext_en.c}, {4'h0, ext.c}, 8'h00, tgl);
    pin_in.c = lvl_c[3:0];
  end
endmodule // gpio3_pins_model

// *** gpio3_top_asserts.sv ***
`timescale 1ns/10ps
module gpio3_top_asserts
  import gpio3_pkg::*;
(
  input wire logic                             clk_sys,
  input wire logic                             reset,
  input wire logic [gpio3_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic                             avs_write,
  input wire logic [gpio3_pkg::AVS_DATA_W-1:0] avs_writedata,
  input wire logic [gpio3_pkg::AVS_BE_W-1:0]   avs_byteenable,
  input wire logic                             avs_waitrequest,
  input wire gpio3_pkg::gpio3_pins_s           pin_in,
  input wire gpio3_pkg::gpio3_pins_s           pin_out,
  input wire gpio3_pkg::gpio3_pins_s           pin_oe,
  input wire logic [gpio3_pkg::PORT_W-1:0]     led_drive_select,
  input wire logic [gpio3_pkg::PORT_W-1:0]     pullup_b_en,
  input wire logic [gpio3_pkg::PORT_W-1:0]     pullup_a_en,
  input wire logic [gpio3_pkg::PORT_W-1:0]     keyboard_irq_pins,
  input wire logic [gpio3_pkg::PORT_W-1:0]     keyboard_irq_enable,
  input wire gpio3_pkg::gpio3_timer_ctrl_s     timer_ctrl,
  input wire logic [gpio3_pkg::PC_W-1:0]       timer_pin_level,
  input wire logic                             timer_ext_clock_pin
);
  // ==========================================================
  // Accepted writes
  wire       acc = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire [5:0] idx = avs_address[7:2];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_dir_a;
    acc && idx == IDX_PORT_A_DIR |-> ##2 pin_oe.a == $past(avs_writedata[7:0], 2);
  endproperty
  property p_rst_dir;
    $fell(reset) |-> pin_oe == '0;
  endproperty
  property p_b_low;
    pin_out.b == '0;
  endproperty
  property p_led;
    acc && idx == IDX_PORT_OPTION |-> ##2 led_drive_select == $past(avs_writedata[7:0], 2);
  endproperty
  property p_pull_b;
    acc && idx == IDX_PULLUP_CTRL |-> ##2 pullup_b_en == $past(avs_writedata[7:0], 2);
  endproperty
  property p_kbd_pull;
    (pullup_a_en == keyboard_irq_enable) and
    (acc && idx == IDX_KEY_IRQ_EN |-> ##2 pullup_a_en == $past(avs_writedata[7:0], 2));
  endproperty
  // Two sync stages plus the output flop
  property p_kbd_pins;
    keyboard_irq_pins == ($past(pin_in.a, 3) & keyboard_irq_enable);
  endproperty
  property p_mode_port;
    timer_ctrl.mode_pair[3] == MODE_PORT |=> !timer_pin_level[3];
  endproperty
  property p_ext_clk;
    timer_ctrl.prescaler != PS_EXT_CLK |=> !timer_ext_clock_pin;
  endproperty
  property p_timer_oe;
    timer_ctrl.mode_pair[3] != MODE_PORT |=> pin_oe.c[3] == $past(timer_ctrl.drive_en[3]);
  endproperty

  a_dir_a:     assert property (p_dir_a) else $error("port A enable not from direction");
  a_rst_dir:   assert property (p_rst_dir) else $error("outputs enabled after reset");
  a_b_low:     assert property (p_b_low) else $error("port B drives high");
  a_led:       assert property (p_led) else $error("led select mismatch");
  a_pull_b:    assert property (p_pull_b) else $error("port B pullup mismatch");
  a_kbd_pull:  assert property (p_kbd_pull) else $error("port A pullup mismatch");
  a_kbd_pins:  assert property (p_kbd_pins) else $error("disabled key pin active");
  a_mode_port: assert property (p_mode_port) else $error("timer sees port pin");
  a_ext_clk:   assert property (p_ext_clk) else $error("ext clock not selected");
  a_timer_oe:  assert property (p_timer_oe) else $error("timer pin enable wrong");

  c_dir_wr: cover property (acc && idx == IDX_PORT_A_DIR);
  c_ext:    cover property (timer_ext_clock_pin);
  c_kbd:    cover property (keyboard_irq_pins != '0);
endmodule // gpio3_top_asserts

bind gpio3_top gpio3_top_asserts chk_u (
  .clk_sys, .reset, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .led_drive_select, .pullup_b_en, .pullup_a_en,
  .keyboard_irq_pins, .keyboard_irq_enable, .timer_ctrl, .timer_pin_level, .timer_ext_clock_pin
);

// *** three_port_gpio_block_tb.sv ***
`timescale 1ns/10ps
module three_port_gpio_block_tb;
  import gpio3_pkg::*;
  logic              clk_sys = 1'b0;
  logic              reset = 1'b1;
  logic [7:0]        avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hF;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  gpio3_pins_s       pin_in, pin_out, pin_oe, ext, ext_en;
  logic [7:0]        led_drive_select, pullup_b_en, pullup_a_en;
  logic [7:0]        keyboard_irq_pins, keyboard_irq_enable;
  gpio3_timer_ctrl_s timer_ctrl = '0;
  logic [3:0]        timer_pin_level, own, oec, outc;
  logic              timer_ext_clock_pin;
  int                n_fail = 0;
  int                compares = 0;
  logic [31:0]       seed, r;
  logic [7:0]        rd, kb, pu, lv, msk;
  logic [7:0]        d [3];
  logic [7:0]        m [3];
  logic [7:0]        lvl [3];
  logic [3:0]        be = 4'hF;
  logic [5:0]        regs [6] = '{IDX_PORT_A_DIR, IDX_PORT_B_DIR, IDX_PORT_C_DIR,
                                  IDX_KEY_IRQ_EN, IDX_PORT_OPTION, IDX_PULLUP_CTRL};

  always #20 clk_sys = ~clk_sys;

  gpio3_top dut_u (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe,
    .led_drive_select, .pullup_b_en, .pullup_a_en, .keyboard_irq_pins,
    .keyboard_irq_enable, .timer_ctrl, .timer_pin_level, .timer_ext_clock_pin);
  gpio3_pins_model pads_u (.clk_sys, .pin_out, .pin_oe, .ext, .ext_en, .pullup_a_en,
    .pullup_b_en, .pin_in);

  // ==========================================================
  // Checking and bus tasks
  task automatic fail(input string s);
    n_fail++;
    $display("ERROR %0t: %s", $time, s);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Ends one edge after release so a new request never lands in the same step
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [7:0] q);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) fail("no bus answer");
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail("watchdog expired");
    test_done;
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'hfaf4196a;
    ext = '0;
    ext_en = '1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk(pin_oe, 32'h0);
    foreach (regs[i]) begin
      bus(1'b0, regs[i], 8'h00, rd);
      chk(rd, 32'h0);
    end
    bus(1'b1, 6'h3F, 8'h5A, rd);
    bus(1'b0, 6'h3F, 8'h00, rd);
    chk(rd, 32'h0);
    for (int it = 0; it < 12; it++) begin
      for (int p = 0; p < 3; p++) begin
        d[p] = 8'($random(seed));
        m[p] = (it == 0) ? 8'h00 : (it == 1) ? 8'hFF : 8'($random(seed));
      end
      kb = 8'($random(seed));
      pu = 8'($random(seed));
      lv = 8'($random(seed));
      r = $random(seed);
      ext <= r[19:0];
      ext_en <= {~kb, ~pu, 4'hF};
      r = $random(seed);
      // Prescaler field sits at bits 10:8; one drive of timer_ctrl per step
      if (it[0]) r[10:8] = PS_EXT_CLK;
      timer_ctrl <= r[22:0];
      for (int p = 0; p < 3; p++) bus(1'b1, 6'(p), d[p], rd);
      for (int p = 0; p < 3; p++) bus(1'b1, 6'(4 + p), m[p], rd);
      bus(1'b1, IDX_KEY_IRQ_EN, kb, rd);
      bus(1'b1, IDX_PULLUP_CTRL, pu, rd);
      bus(1'b1, IDX_PORT_OPTION, lv, rd);
      repeat (4) @(posedge clk_sys);
      own[0] = timer_ctrl.mode_pair[0] != MODE_PORT && timer_ctrl.els_ch0 != ELS_PORT;
      own[1] = timer_ctrl.mode_pair[1] != MODE_PORT && timer_ctrl.prescaler == PS_EXT_CLK;
      own[2] = timer_ctrl.mode_pair[2] != MODE_PORT && timer_ctrl.els_ch1 != ELS_PORT;
      own[3] = timer_ctrl.mode_pair[3] != MODE_PORT;
      oec = (own & timer_ctrl.drive_en) | (~own & m[2][3:0]);
      outc = (own & timer_ctrl.drive) | (~own & d[2][3:0]);
      lvl[0] = (m[0] & d[0]) | (~m[0] & (kb | ext.a));
      lvl[1] = ~(m[1] & ~d[1]) & (pu | ext.b);
      lvl[2] = {4'h0, (oec & outc) | (~oec & ext.c)};
      chk(pin_oe, {m[0], m[1] & ~d[1], oec});
      chk({pin_out.a, pin_out.c}, {d[0], outc});
      chk(keyboard_irq_pins, lvl[0] & kb);
      chk({keyboard_irq_enable, pullup_a_en, pullup_b_en, led_drive_select},
          {kb, kb, pu, lv});
      chk(timer_pin_level, lvl[2][3:0] & own);
      chk(timer_ext_clock_pin, (timer_ctrl.prescaler == PS_EXT_CLK) & lvl[2][1]);
      for (int p = 0; p < 3; p++) begin
        msk = (p == 2) ? 8'h0F : 8'hFF;
        bus(1'b0, 6'(p), 8'h00, rd);
        chk(rd, ((m[p] & d[p]) | (~m[p] & lvl[p])) & msk);
        bus(1'b0, 6'(4 + p), 8'h00, rd);
        chk(rd, m[p] & msk);
      end
    end
    be = 4'h0;
    bus(1'b1, IDX_PORT_A_DATA, ~d[0], rd);
    be = 4'hF;
    reset <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk(pin_oe, 32'h0);
    bus(1'b1, IDX_PORT_A_DIR, 8'hFF, rd);
    bus(1'b0, IDX_PORT_A_DATA, 8'h00, rd);
    chk(rd, d[0]);
    test_done;
  end
endmodule // three_port_gpio_block_tb
